// ---- logic/smsio_pkg.sv ----
// constants, carriers and decode for the start-up mode shift port
package smsio_pkg;
  // timing
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned SHIFT_HALF_NS = 40;
  localparam int unsigned HALF_RAW = (SHIFT_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam logic [2:0] SHIFT_HALF_CYC = 3'(HALF_RAW < 1 ? 1 : HALF_RAW);
  localparam logic [1:0] CFG_SETTLE_CYC = 2'h2;
  // register byte offsets, and block numbers for paddr[7:5]
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LAYOUT = 8'h08;
  localparam logic [2:0] REG_OUT_BLK = 3'h1;
  localparam logic [2:0] REG_IN_BLK = 3'h2;
  // field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_AUTO = 1;
  localparam int CTRL_ADC = 2;
  localparam int STAT_SIMPLE = 4;
  localparam int STAT_HOST = 5;
  localparam int STAT_RSVD = 6;
  localparam int STAT_BUSY = 7;
  localparam int STAT_DONE = 8;
  localparam int STAT_VALID = 9;
  localparam int LAY_IN = 0;
  localparam int LAY_OUT = 8;
  localparam int LAY_ADC = 16;
  // layout figures
  localparam logic [5:0] ADC_BYTES = 6'h04;
  localparam logic [3:0] CODE_MODBUS = 4'h8;
  localparam logic [3:0] CODE_SPI = 4'h9;

  typedef struct packed {
    logic simple;
    logic host;
    logic modbus;
    logic spi;
    logic rsvd;
    logic analog;
    logic [5:0] sr_bytes;
    logic [5:0] in_bytes;
  } smsio_layout_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } smsio_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } smsio_apb_rsp_t;

  typedef struct packed {
    logic shift_clk;
    logic shift_serial_out;
    logic input_latch_strobe;
    logic output_latch_strobe;
  } smsio_shift_out_t;

  function automatic smsio_layout_t smsio_decode(input logic [3:0] code);
    smsio_layout_t l;
    l = '0;
    l.simple = (code < 4'h6);
    l.analog = (code < 4'h3);
    unique case (code)
      4'h0, 4'h3: l.sr_bytes = 6'h04;
      4'h1, 4'h4: l.sr_bytes = 6'h08;
      4'h2: l.sr_bytes = 6'h1c;
      4'h5: l.sr_bytes = 6'h20;
      CODE_MODBUS: l.modbus = 1'b1;
      CODE_SPI: l.spi = 1'b1;
      default: l.rsvd = 1'b1;
    endcase
    l.host = l.modbus | l.spi;
    l.in_bytes = l.sr_bytes + (l.analog ? ADC_BYTES : 6'h00);
    return l;
  endfunction

  function automatic logic [255:0] smsio_mask(input logic [5:0] n);
    logic [255:0] m;
    m = '0;
    for (int i = 0; i < 32; i++) begin
      if (i < n) m[i*8 +: 8] = 8'hff;
    end
    return m;
  endfunction
endpackage

// ---- logic/smsio_sync.sv ----
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module smsio_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ---- logic/smsio_cfg.sv ----
// start-up pin capture and mode decode, held until next reset
`timescale 1ns/1ns
module smsio_cfg import smsio_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // configuration pins
  input wire logic [3:0] startup_config_pins,
  // decoded mode
  output logic [3:0] code_q,
  output smsio_layout_t layout_q,
  output logic valid_q
);
  logic [3:0] pins_s;
  logic [1:0] settle_q, settle_d;
  logic [3:0] code_d;
  logic valid_d;
  smsio_layout_t layout_d;

  smsio_sync #(.W(4)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(startup_config_pins),
    .q(pins_s)
  );

  // capture once, after the synchroniser has filled
  always_comb begin
    settle_d = settle_q;
    code_d = code_q;
    valid_d = valid_q;
    layout_d = layout_q;
    if (!valid_q) begin
      if (settle_q == CFG_SETTLE_CYC) begin
        valid_d = 1'b1; // RULE19
        code_d = pins_s;
        layout_d = smsio_decode(pins_s);
      end else begin
        settle_d = settle_q + 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_q <= '0;
      code_q <= '0;
      valid_q <= 1'b0;
      layout_q <= '0;
    end else begin
      settle_q <= settle_d;
      code_q <= code_d;
      valid_q <= valid_d;
      layout_q <= layout_d;
    end
  end

  a_cfg_held: assert property (@(posedge pclk) disable iff (!presetn)
    $past(valid_q) |-> valid_q && $stable(code_q)) // RULE19
    else $error("config changed after capture");
endmodule

// ---- logic/smsio_top.sv ----
// start-up mode decode and shift-register process data port
// Summary of operation
// RULE1 - code 0000: analog 4 bytes first, 4 shift bytes; 8 in, 4 out
// RULE2 - code 0001: analog 4 bytes, 8 shift bytes; 12 in, 8 out
// RULE3 - code 0010: analog 4 bytes, 28 shift bytes; 32 in, 28 out
// RULE4 - codes 0011/0100/0101: shift only, 4/8/32 bytes from byte zero
// RULE5 - codes 0110, 0111, 1010-1111 reserved; port stays idle
// RULE6 - code 1000: host mode over serial modbus host interface
// RULE7 - code 1001: host mode over spi register host interface
// RULE8 - host mode: protocol only, external host supplies process data
// RULE9 - simple mode: exchange over shift port, analog sampled if enabled
// RULE10 - on-board chain: 16-bit switch word in, 16-bit led word out
// RULE11 - first led carries output bit zero, sixteenth the top bit
// RULE12 - header device trades 8 bits, mirrors upper eight led bits
// RULE13 - device drives the shift clock, far side only receives it
// RULE14 - serial input sampled in step with the shift clock
// RULE15 - output data driven one bit per shift clock
// RULE16 - input latch pulsed before shifting starts
// RULE17 - output latch pulsed after shifting, all outputs together
// RULE18 - host mode keeps the analog converter disabled
// RULE19 - config pins sampled once after reset, held until next reset
// RULE20 - exchange: input latch, shift both ways, then output latch
// RULE21 - clock idle and latches low between exchanges and in host mode
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ns
module smsio_top import smsio_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire smsio_apb_req_t apb_req,
  output smsio_apb_rsp_t apb_rsp,
  // configuration pins
  input wire logic [3:0] startup_config_pins,
  // shift register port
  input wire logic shift_serial_in,
  output smsio_shift_out_t shift_port,
  // analog converter
  input wire logic [31:0] analog_bytes,
  output logic adc_enable,
  // host interface selects
  output logic host_modbus_sel,
  output logic host_spi_sel
);
  typedef enum logic [2:0] {
    PH_IDLE, PH_IN_LATCH, PH_CLK_LOW, PH_CLK_HIGH, PH_OUT_LATCH
  } smsio_state_t;

  logic [3:0] code;
  smsio_layout_t lay;
  logic cfg_valid;
  logic ser_in_s;

  smsio_cfg u_cfg (
    .pclk(pclk),
    .presetn(presetn),
    .startup_config_pins(startup_config_pins),
    .code_q(code),
    .layout_q(lay),
    .valid_q(cfg_valid)
  );

  smsio_sync #(.W(1)) u_ser_in (
    .pclk(pclk),
    .presetn(presetn),
    .d(shift_serial_in),
    .q(ser_in_s)
  );

  // apb decode
  smsio_apb_rsp_t rsp_q, rsp_d;
  logic access, wr;
  logic [2:0] blk;
  logic [2:0] widx;
  assign access = apb_req.psel & apb_req.penable & rsp_q.pready;
  assign wr = access & apb_req.pwrite;
  assign blk = apb_req.paddr[7:5];
  assign widx = apb_req.paddr[4:2];

  // control registers
  logic auto_q, auto_d, adc_en_q, adc_en_d;
  logic start_q, start_d, done_q, done_d;
  logic [7:0][31:0] process_output_bytes_q, process_output_bytes_d;
  logic [7:0][31:0] process_input_bytes_q, process_input_bytes_d;
  logic exch_begin, exch_end, busy;

  // exchange engine state
  smsio_state_t ph_q, ph_d;
  logic [2:0] tmr_q, tmr_d;
  logic [8:0] cnt_q, cnt_d;
  logic [7:0] top_q, top_d;
  logic [255:0] shf_q, shf_d;
  logic sbit_q, sbit_d;
  smsio_shift_out_t so_q, so_d;
  logic adc_q, modbus_q, spi_q;
  logic half_end, go;
  logic [255:0] in_vec;

  assign busy = (ph_q != PH_IDLE);

  // register read path and answer, ready given in the access phase
  always_comb begin
    rsp_d = '0;
    if (apb_req.psel && !apb_req.penable) begin
      rsp_d.pready = 1'b1;
      if (apb_req.paddr[1:0] != 2'h0) begin
        rsp_d.pslverr = 1'b1;
      end else if (apb_req.paddr == REG_CTRL) begin
        rsp_d.prdata[CTRL_AUTO] = auto_q;
        rsp_d.prdata[CTRL_ADC] = adc_en_q;
        rsp_d.prdata[CTRL_START] = start_q;
      end else if (apb_req.paddr == REG_STATUS) begin
        rsp_d.prdata[3:0] = code;
        rsp_d.prdata[STAT_SIMPLE] = cfg_valid & lay.simple;
        rsp_d.prdata[STAT_HOST] = cfg_valid & lay.host;
        rsp_d.prdata[STAT_RSVD] = cfg_valid & lay.rsvd;
        rsp_d.prdata[STAT_BUSY] = busy;
        rsp_d.prdata[STAT_DONE] = done_q;
        rsp_d.prdata[STAT_VALID] = cfg_valid;
      end else if (apb_req.paddr == REG_LAYOUT) begin
        rsp_d.prdata[LAY_IN +: 6] = lay.in_bytes;
        rsp_d.prdata[LAY_OUT +: 6] = lay.sr_bytes;
        rsp_d.prdata[LAY_ADC] = lay.analog;
      end else if (blk == REG_OUT_BLK) begin
        rsp_d.prdata = process_output_bytes_q[widx];
      end else if (blk == REG_IN_BLK) begin
        rsp_d.prdata = process_input_bytes_q[widx];
      end else begin
        rsp_d.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // software control; hardware set wins over software clear
  always_comb begin
    auto_d = auto_q;
    adc_en_d = adc_en_q;
    process_output_bytes_d = process_output_bytes_q;
    start_d = start_q & ~exch_begin;
    done_d = done_q;
    if (wr && apb_req.paddr == REG_CTRL) begin
      auto_d = apb_req.pwdata[CTRL_AUTO];
      adc_en_d = apb_req.pwdata[CTRL_ADC];
      start_d = start_d | apb_req.pwdata[CTRL_START];
    end
    if (wr && apb_req.paddr == REG_STATUS && apb_req.pwdata[STAT_DONE]) begin
      done_d = 1'b0;
    end
    if (wr && blk == REG_OUT_BLK && apb_req.paddr[1:0] == 2'h0) begin
      process_output_bytes_d[widx] = apb_req.pwdata;
    end
    if (exch_end) begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_q <= 1'b0;
      adc_en_q <= 1'b0;
      start_q <= 1'b0;
      done_q <= 1'b0;
      process_output_bytes_q <= '0;
    end else begin
      auto_q <= auto_d;
      adc_en_q <= adc_en_d;
      start_q <= start_d;
      done_q <= done_d;
      process_output_bytes_q <= process_output_bytes_d;
    end
  end

  // only simple mode with a nonzero chain ever starts a frame
  assign go = cfg_valid & lay.simple & (start_q | auto_q); // RULE5 RULE8 RULE9
  assign half_end = (tmr_q == SHIFT_HALF_CYC - 3'h1);

  // analog bytes lead the input image in analog modes
  always_comb begin
    in_vec = shf_q & smsio_mask(lay.sr_bytes);
    if (lay.analog) begin
      in_vec = {in_vec[223:0], (adc_en_q ? analog_bytes : 32'h0)}; // RULE1 RULE2 RULE3 RULE9
    end
    in_vec = in_vec & smsio_mask(lay.in_bytes); // RULE4
  end

  // exchange engine
  always_comb begin
    ph_d = ph_q;
    tmr_d = tmr_q + 3'h1;
    cnt_d = cnt_q;
    top_d = top_q;
    shf_d = shf_q;
    sbit_d = sbit_q;
    so_d = so_q;
    process_input_bytes_d = process_input_bytes_q;
    exch_begin = 1'b0;
    exch_end = 1'b0;
    unique case (ph_q)
      PH_IDLE: begin
        tmr_d = '0;
        so_d.shift_clk = 1'b0; // RULE21
        so_d.input_latch_strobe = 1'b0;
        so_d.output_latch_strobe = 1'b0;
        if (go) begin
          exch_begin = 1'b1;
          ph_d = PH_IN_LATCH;
          so_d.input_latch_strobe = 1'b1; // RULE16 RULE20
          cnt_d = {lay.sr_bytes, 3'h0};
          top_d = 8'({lay.sr_bytes, 3'h0} - 9'h001);
          // top byte leaves first so byte zero bit zero lands nearest
          shf_d = process_output_bytes_q & smsio_mask(lay.sr_bytes); // RULE10 RULE11
        end
      end
      PH_IN_LATCH: begin
        if (half_end) begin
          tmr_d = '0;
          so_d.input_latch_strobe = 1'b0;
          ph_d = PH_CLK_LOW;
        end
      end
      PH_CLK_LOW: begin
        so_d.shift_serial_out = shf_q[top_q]; // RULE15
        if (half_end) begin
          tmr_d = '0;
          // sample before the rise, the far chain moves on the rise
          sbit_d = ser_in_s; // RULE14
          so_d.shift_clk = 1'b1; // RULE13
          ph_d = PH_CLK_HIGH;
        end
      end
      PH_CLK_HIGH: begin
        if (half_end) begin
          tmr_d = '0;
          so_d.shift_clk = 1'b0;
          shf_d = {shf_q[254:0], sbit_q}; // RULE20
          cnt_d = cnt_q - 9'h001;
          if (cnt_q == 9'h001) begin
            so_d.output_latch_strobe = 1'b1; // RULE17
            ph_d = PH_OUT_LATCH;
          end else begin
            ph_d = PH_CLK_LOW;
          end
        end
      end
      PH_OUT_LATCH: begin
        if (half_end) begin
          tmr_d = '0;
          so_d.output_latch_strobe = 1'b0;
          process_input_bytes_d = in_vec;
          exch_end = 1'b1;
          ph_d = PH_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= PH_IDLE;
      tmr_q <= '0;
      cnt_q <= '0;
      top_q <= '0;
      shf_q <= '0;
      sbit_q <= 1'b0;
      so_q <= '0;
      process_input_bytes_q <= '0;
    end else begin
      ph_q <= ph_d;
      tmr_q <= tmr_d;
      cnt_q <= cnt_d;
      top_q <= top_d;
      shf_q <= shf_d;
      sbit_q <= sbit_d;
      so_q <= so_d;
      process_input_bytes_q <= process_input_bytes_d;
    end
  end

  // mode outputs, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_q <= 1'b0;
      modbus_q <= 1'b0;
      spi_q <= 1'b0;
    end else begin
      adc_q <= adc_en_q & cfg_valid & lay.simple; // RULE18 RULE9
      modbus_q <= cfg_valid & lay.modbus; // RULE6
      spi_q <= cfg_valid & lay.spi; // RULE7
    end
  end

  assign apb_rsp = rsp_q;
  assign shift_port = so_q;
  assign adc_enable = adc_q;
  assign host_modbus_sel = modbus_q;
  assign host_spi_sel = spi_q;

  // helper: shift clock rises seen in the current frame
  logic [8:0] rises_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rises_q <= '0;
    end else if (ph_q == PH_IDLE) begin
      rises_q <= '0;
    end else if (so_d.shift_clk && !so_q.shift_clk) begin
      rises_q <= rises_q + 9'h001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_host_port_idle: assert property ($past(cfg_valid) && lay.host |->
    !so_q.shift_clk && !so_q.input_latch_strobe
    && !so_q.output_latch_strobe) // RULE21
    else $error("shift port active in host mode");
  a_host_adc_off: assert property (lay.host |-> !adc_enable) // RULE18
    else $error("converter enabled in host mode");
  a_rsvd_silent: assert property (lay.rsvd |-> !so_q.input_latch_strobe) // RULE5
    else $error("exchange started on reserved code");
  a_li_pulse: assert property ($rose(so_q.input_latch_strobe) |->
    (so_q.input_latch_strobe && !so_q.shift_clk)[*4]
    ##1 !so_q.input_latch_strobe) // RULE16
    else $error("input latch pulse wrong");
  a_clk_high: assert property ($rose(so_q.shift_clk) |->
    so_q.shift_clk[*4] ##1 !so_q.shift_clk) // RULE13
    else $error("shift clock high phase wrong");
  a_sdo_stable: assert property (so_q.shift_clk |->
    $stable(so_q.shift_serial_out)) // RULE15
    else $error("serial out moved while clock high");
  a_frame_bits: assert property ($rose(so_q.output_latch_strobe) |->
    rises_q == {lay.sr_bytes, 3'h0} && !so_q.shift_clk) // RULE20
    else $error("wrong bit count before output latch");
  a_lo_to_done: assert property ($rose(so_q.output_latch_strobe) |->
    ##4 done_q && !busy) // RULE17
    else $error("frame did not close after output latch");
  a_layout_28: assert property (cfg_valid && code == 4'h2 |->
    lay.in_bytes == 6'h20 && lay.sr_bytes == 6'h1c) // RULE3
    else $error("layout for code 2 wrong");
  a_apb_ready: assert property (apb_req.psel && !apb_req.penable |=>
    apb_rsp.pready)
    else $error("apb answer late");

  c_frame: cover property ($rose(so_q.output_latch_strobe));
  c_host: cover property (host_spi_sel || host_modbus_sel);
  c_adc_frame: cover property (exch_end && lay.analog && adc_en_q);
  c_long_frame: cover property (exch_end && lay.sr_bytes == 6'h20);
endmodule

// ---- test/smsio_chain_model.sv ----
// behavioural model of the external shift register chain
`timescale 1ns/1ns
module smsio_chain_model #(
  parameter int DLY = 5
) (
  // shift port driven by the block
  input wire logic shift_clk,
  input wire logic shift_serial_out,
  input wire logic input_latch_strobe,
  input wire logic output_latch_strobe,
  output logic shift_serial_in,
  // parallel sides and bit count
  input wire logic [8:0] n_bits,
  input wire logic [255:0] parallel_in_bits,
  output logic [255:0] parallel_out_bits,
  output logic [8:0] n_clk
);
  logic [255:0] in_q = '0;
  logic [255:0] out_q = '0;
  initial parallel_out_bits = '0;
  initial n_clk = '0;
  // capture switches and restart the clock count
  always @(posedge input_latch_strobe) begin
    in_q = parallel_in_bits;
    n_clk = '0;
  end
  always @(posedge shift_clk) begin
    out_q = {out_q[254:0], shift_serial_out};
    in_q = in_q << 1;
    n_clk = n_clk + 9'h1;
  end
  // chain output moves after the rise, long before the next sample
  assign #DLY shift_serial_in = in_q[n_bits - 9'h1];
  // all parallel outputs update together
  always @(posedge output_latch_strobe) begin
    parallel_out_bits = out_q;
  end
endmodule

// ---- test/startup_mode_shift_io_bench.sv ----
// self-checking bench for the start-up mode shift port
`timescale 1ns/1ns
module startup_mode_shift_io_bench;
  import smsio_pkg::*;
  logic pclk;
  logic presetn;
  smsio_apb_req_t apb_req;
  smsio_apb_rsp_t apb_rsp;
  logic [3:0] cfg;
  logic ser_in;
  smsio_shift_out_t port;
  logic [31:0] analog_in;
  logic adc_en;
  logic mb_sel;
  logic spi_sel;
  logic [8:0] n_bits;
  logic [8:0] n_clk;
  logic [255:0] par_in;
  logic [255:0] par_out;
  int n_mismatch;
  int n_compared;

  smsio_top i_smsio_top (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .startup_config_pins(cfg),
    .shift_serial_in(ser_in),
    .shift_port(port),
    .analog_bytes(analog_in),
    .adc_enable(adc_en),
    .host_modbus_sel(mb_sel),
    .host_spi_sel(spi_sel)
  );

  smsio_chain_model i_smsio_chain_model (
    .shift_clk(port.shift_clk),
    .shift_serial_out(port.shift_serial_out),
    .input_latch_strobe(port.input_latch_strobe),
    .output_latch_strobe(port.output_latch_strobe),
    .shift_serial_in(ser_in),
    .n_bits(n_bits),
    .parallel_in_bits(par_in),
    .parallel_out_bits(par_out),
    .n_clk(n_clk)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until the edge that samples pready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int i;
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (apb_rsp.pready === 1'b1) break;
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    if (i == 16) begin
      n_mismatch++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  // pins settle before release; capture follows release
  task automatic boot(input logic [3:0] code);
    presetn <= 1'b0;
    cfg <= code;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask

  task automatic wait_done();
    logic [31:0] s;
    int i;
    for (i = 0; i < 1000; i++) begin
      rd(REG_STATUS, s);
      if (s[STAT_DONE] === 1'b1) break;
    end
    if (i == 1000) begin
      n_mismatch++;
      end_of_test();
    end
  endtask

  function automatic logic [5:0] sr_of(input logic [3:0] c);
    case (c)
      4'h0, 4'h3: return 6'h04;
      4'h1, 4'h4: return 6'h08;
      4'h2: return 6'h1c;
      4'h5: return 6'h20;
      default: return 6'h00;
    endcase
  endfunction

  function automatic logic [31:0] pat(input logic [31:0] s, input int k);
    return s ^ (32'h0101_0101 * 32'(k + 1));
  endfunction

  task automatic t_modes();
    logic [31:0] s;
    logic [31:0] l;
    logic [31:0] es;
    logic [31:0] el;
    logic an;
    logic hm;
    for (int c = 0; c < 16; c++) begin
      boot(4'(c));
      an = (c < 3);
      hm = (c == 8 || c == 9);
      el = {15'h0, an, 2'h0, sr_of(4'(c)), 2'h0,
            sr_of(4'(c)) + (an ? 6'h04 : 6'h00)};
      es = 32'(c);
      es[STAT_SIMPLE] = (c < 6);
      es[STAT_HOST] = hm;
      es[STAT_RSVD] = !(c < 6) && !hm;
      es[STAT_VALID] = 1'b1;
      rd(REG_STATUS, s);
      chk("status", es, s);
      rd(REG_LAYOUT, l);
      chk("layout", el, l);
      chk("host sel", {30'h0, c == 8, c == 9}, {30'h0, mb_sel, spi_sel});
    end
    $display("test modes done");
  endtask

  // widest chain: byte order end to end over 256 bits
  task automatic t_shift();
    logic [31:0] r;
    boot(4'h5);
    n_bits <= 9'h100;
    for (int k = 0; k < 8; k++) begin
      wr(8'h20 + 8'(4 * k), pat(32'h9e37_79b9, k));
      par_in[32 * k +: 32] <= pat(32'h5bd1_e995, k);
    end
    wr(REG_CTRL, 32'h1);
    wait_done();
    chk("clocks", 32'h100, {23'h0, n_clk});
    chk("led word", pat(32'h9e37_79b9, 0) & 32'h0000_ffff,
        {16'h0, par_out[15:0]});
    for (int k = 0; k < 8; k++) begin
      chk("chain out", pat(32'h9e37_79b9, k), par_out[32 * k +: 32]);
      rd(8'h40 + 8'(4 * k), r);
      chk("proc in", pat(32'h5bd1_e995, k), r);
    end
    $display("test shift done");
  endtask

  task automatic t_analog();
    logic [31:0] r;
    boot(4'h0);
    n_bits <= 9'h020;
    analog_in <= 32'hc0de_4a71;
    par_in <= 256'h3c96_a50f;
    wr(8'h20, 32'h8001_7e18);
    wr(REG_CTRL, 32'h5);
    // enable lands at the access edge, the pin one edge later
    repeat (2) @(posedge pclk);
    chk("adc on", 32'h1, {31'h0, adc_en});
    wait_done();
    chk("idle", 32'h0, {29'h0, port.shift_clk, port.input_latch_strobe,
        port.output_latch_strobe});
    chk("clocks", 32'h20, {23'h0, n_clk});
    chk("chain out", 32'h8001_7e18, par_out[31:0]);
    rd(8'h40, r);
    chk("analog", 32'hc0de_4a71, r);
    rd(8'h44, r);
    chk("proc in", 32'h3c96_a50f, r);
    $display("test analog done");
  endtask

  // host or reserved: port must never move
  task automatic t_host(input logic [3:0] code);
    logic [31:0] s;
    logic act;
    boot(code);
    cfg <= 4'h0;
    act = 1'b0;
    wr(REG_CTRL, 32'h5);
    repeat (300) begin
      @(posedge pclk);
      act |= port.shift_clk | port.input_latch_strobe;
      act |= port.output_latch_strobe;
    end
    chk("port quiet", 32'h0, {31'h0, act});
    chk("adc off", 32'h0, {31'h0, adc_en});
    rd(REG_STATUS, s);
    chk("held code", {28'h0, code}, {28'h0, s[3:0]});
    $display("test host done");
  endtask

  task automatic t_errors();
    logic [31:0] r;
    logic e;
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk("unmapped", 32'h1, {31'h0, e});
    apb(1'b1, 8'h02, 32'h1, r, e);
    chk("misaligned", 32'h1, {31'h0, e});
    $display("test errors done");
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    presetn = 1'b0;
    apb_req = '0;
    cfg = 4'h0;
    analog_in = '0;
    par_in = '0;
    n_bits = 9'h020;
    n_mismatch = 0;
    n_compared = 0;
    t_modes();
    t_shift();
    t_analog();
    t_host(4'h9);
    t_host(4'hc);
    t_errors();
    end_of_test();
  end
endmodule
